// *** verilog/ptp_time_clock.v ***
// Precision time system clock: APB registers, time keeping, target compare
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
`include "ptp_time_consts.vh"

// Contract
// - Enable bit runs time; software reinitialises after
// - Select bit picks coarse or fine update
// - Initialise bit loads time, then self-clears
// - Offset bit applies update value, then self-clears
// - Sign bit set subtracts offset, else adds
// - Armed target below time raises interrupt
// - Interrupt clears arm bit, one per arming
// - Addend-load bit copies addend, then self-clears
// - Eight-bit step added at each update event
// - Seconds readable as 32-bit read-only value
// - Subseconds readable as 31-bit field, 0.46ns
// - Bit 31 of subseconds shows time sign
// - Writable update seconds and subseconds registers
// - Writable 32-bit addend feeds the accumulator
// - Compare seconds and nanoseconds target, equal passes
// - Node type 0X snapshot selection
// - Node type 11 snapshot selection
module ptp_time_clock
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output reg target_reached,
	output reg [31:0] current_seconds,
	output reg [30:0] current_subseconds,
	output reg current_time_sign,
	output reg [5:0] snapshot_messages
);

// ==========================================================
// Helpers

// Snapshot message set for the selected node and mode
function [5:0] snapshot_set;
	input [1:0] node;
	input master;
	input event_only;
	reg [5:0] m;
	begin
		m = 6'h00;
		if (node == `NODE_PEER)
		begin
			m[`SNAP_SYNC] = 1'b1;
			m[`SNAP_PDELAY_REQ] = 1'b1;
			m[`SNAP_PDELAY_RESP] = 1'b1;
			if (!event_only)
			begin
				m[`SNAP_FOLLOW_UP] = 1'b1;
				m[`SNAP_DELAY_REQ] = 1'b1;
				m[`SNAP_DELAY_RESP] = 1'b1;
			end
		end
		else if (node == `NODE_BOUNDARY_E2E)
		begin
			m[`SNAP_SYNC] = 1'b1;
			m[`SNAP_FOLLOW_UP] = 1'b1;
			if (!event_only)
			begin
				m[`SNAP_DELAY_REQ] = 1'b1;
				m[`SNAP_DELAY_RESP] = 1'b1;
			end
		end
		else if (!event_only)
		begin
			m[`SNAP_SYNC] = 1'b1;
			m[`SNAP_FOLLOW_UP] = 1'b1;
			m[`SNAP_DELAY_REQ] = 1'b1;
			m[`SNAP_DELAY_RESP] = 1'b1;
		end
		else if (master)
		begin
			m[`SNAP_DELAY_REQ] = 1'b1;
		end
		else
		begin
			m[`SNAP_SYNC] = 1'b1;
		end
		snapshot_set = m;
	end
endfunction

// ==========================================================
// Register state
reg timestamping_enable;
reg fine_or_coarse_select;
reg time_initialise_bit;
reg time_offset_update_bit;
reg target_interrupt_arm;
reg addend_load_bit;
reg event_only_select;
reg master_node_select;
reg [1:0] clock_node_type;
reg [7:0] subsecond_step;
reg [31:0] offset_seconds;
reg [30:0] offset_subseconds;
reg offset_negative;
reg [31:0] addend_value;
reg [31:0] target_seconds;
reg [31:0] target_nanoseconds;

// ==========================================================
// Time keeping state
// Time is one 64-bit two's complement word: sign, seconds, subseconds.
// Subseconds roll over in binary at bit 31 straight into the seconds.
reg [63:0] system_time;
reg [31:0] active_addend;
reg [31:0] accumulator;

// ==========================================================
// APB decode
wire setup_phase;
wire write_access;
wire mapped;
reg [31:0] read_word;
reg hit;

assign setup_phase = psel & ~penable;
assign write_access = psel & penable & pwrite;
// Zero wait states: read data is captured during the setup cycle
assign pready = 1'b1;
assign mapped = hit;
assign pslverr = psel & penable & ~mapped;

// One strobe per writable register, decoded once for every consumer
wire write_control;
wire write_step;
wire write_offset_seconds;
wire write_offset_subseconds;
wire write_addend;
wire write_target_seconds;
wire write_target_nanoseconds;

assign write_control = write_access & (paddr == `OFF_TIMESTAMP_CONTROL);
assign write_step = write_access & (paddr == `OFF_SUBSECOND_INCREMENT);
assign write_offset_seconds = write_access & (paddr == `OFF_UPDATE_SECONDS);
assign write_offset_subseconds = write_access & (paddr == `OFF_UPDATE_SUBSECONDS);
assign write_addend = write_access & (paddr == `OFF_FREQUENCY_ADDEND);
assign write_target_seconds = write_access & (paddr == `OFF_TARGET_TIME_SECONDS);
assign write_target_nanoseconds = write_access & (paddr == `OFF_TARGET_TIME_NANOSECONDS);

wire [31:0] control_word;
assign control_word = (32'h1 << `CTRL_FIXED_ONE)
	| ({31'h0, timestamping_enable} << `CTRL_ENABLE)
	| ({31'h0, fine_or_coarse_select} << `CTRL_FINE)
	| ({31'h0, time_initialise_bit} << `CTRL_INIT)
	| ({31'h0, time_offset_update_bit} << `CTRL_UPDATE)
	| ({31'h0, target_interrupt_arm} << `CTRL_ARM)
	| ({31'h0, addend_load_bit} << `CTRL_ADDEND_LOAD)
	| ({31'h0, event_only_select} << `CTRL_EVENT_ONLY)
	| ({31'h0, master_node_select} << `CTRL_MASTER_NODE)
	| ({30'h0, clock_node_type} << `CTRL_NODE_LO);

always @*
begin
	hit = 1'b1;
	read_word = 32'h00000000;
	case (paddr)
		`OFF_TIMESTAMP_CONTROL: read_word = control_word;
		`OFF_SUBSECOND_INCREMENT: read_word = {24'h000000, subsecond_step};
		`OFF_SYSTEM_TIME_SECONDS: read_word = system_time[62:31];
		`OFF_SYSTEM_TIME_SUBSECONDS: read_word = {system_time[63], system_time[30:0]};
		`OFF_UPDATE_SECONDS: read_word = offset_seconds;
		`OFF_UPDATE_SUBSECONDS: read_word = {offset_negative, offset_subseconds};
		`OFF_FREQUENCY_ADDEND: read_word = addend_value;
		`OFF_TARGET_TIME_SECONDS: read_word = target_seconds;
		`OFF_TARGET_TIME_NANOSECONDS: read_word = target_nanoseconds;
		default: hit = 1'b0;
	endcase
end

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		prdata <= 32'h00000000;
	else if (setup_phase && !pwrite)
		prdata <= read_word;
end

// ==========================================================
// Time arithmetic
wire [32:0] accumulate_sum;
wire step_event;
wire [63:0] advanced_time;
wire [63:0] offset_value;
wire [63:0] next_time;
wire target_passed;

assign accumulate_sum = {1'b0, accumulator} + {1'b0, active_addend};
// Fine mode steps only on accumulator overflow, coarse on every clock
assign step_event = timestamping_enable
	& (fine_or_coarse_select ? accumulate_sum[32] : 1'b1);
assign advanced_time = system_time
	+ (step_event ? {56'h0, subsecond_step} : 64'h0);
assign offset_value = {1'b0, offset_seconds, offset_subseconds};
assign next_time = time_initialise_bit ? offset_value
	: time_offset_update_bit ? (offset_negative ? advanced_time - offset_value
	: advanced_time + offset_value)
	: advanced_time;
// A negative time never counts as past the target
assign target_passed = ~system_time[63]
	& (system_time[62:0] >= {target_seconds, target_nanoseconds[30:0]});

// ==========================================================
// System time
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		system_time <= 64'h0;
	end
	else
	begin
		// Suspended while disabled: software must reinitialise afterwards
		if (timestamping_enable || time_initialise_bit || time_offset_update_bit)
			system_time <= next_time;
	end
end

// ==========================================================
// Fine-calibration accumulator
// The addend in use is a copy, so a half-written addend never drifts the clock
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		accumulator <= 32'h00000000;
		active_addend <= 32'h00000000;
	end
	else
	begin
		if (timestamping_enable && fine_or_coarse_select)
			accumulator <= accumulate_sum[31:0];
		if (addend_load_bit)
			active_addend <= addend_value;
	end
end

// ==========================================================
// Command bits and target interrupt
reg next_initialise;
reg next_offset_update;
reg next_addend_load;
reg next_arm;
reg next_reached;

always @*
begin
	// Command bits act for one clock and then clear themselves
	next_initialise = 1'b0;
	next_offset_update = 1'b0;
	next_addend_load = 1'b0;
	next_arm = target_interrupt_arm;
	next_reached = 1'b0;
	if (target_interrupt_arm && target_passed)
	begin
		next_reached = 1'b1;
		next_arm = 1'b0;
	end
	// A software write lands after the hardware clears, so it wins
	if (write_control)
	begin
		next_initialise = pwdata[`CTRL_INIT];
		next_offset_update = pwdata[`CTRL_UPDATE];
		next_addend_load = pwdata[`CTRL_ADDEND_LOAD];
		next_arm = pwdata[`CTRL_ARM];
	end
end

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		time_initialise_bit <= 1'b0;
		time_offset_update_bit <= 1'b0;
		addend_load_bit <= 1'b0;
		target_interrupt_arm <= 1'b0;
		target_reached <= 1'b0;
	end
	else
	begin
		time_initialise_bit <= next_initialise;
		time_offset_update_bit <= next_offset_update;
		addend_load_bit <= next_addend_load;
		target_interrupt_arm <= next_arm;
		target_reached <= next_reached;
	end
end

// ==========================================================
// Registers written by software
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		timestamping_enable <= 1'b0;
		fine_or_coarse_select <= 1'b0;
		event_only_select <= 1'b0;
		master_node_select <= 1'b0;
		clock_node_type <= 2'h0;
		subsecond_step <= 8'h00;
		offset_seconds <= `RST_WORD;
		offset_subseconds <= 31'h0;
		offset_negative <= 1'b0;
		addend_value <= `RST_WORD;
		target_seconds <= `RST_WORD;
		target_nanoseconds <= `RST_WORD;
	end
	else
	begin
		if (write_control)
		begin
			timestamping_enable <= pwdata[`CTRL_ENABLE];
			fine_or_coarse_select <= pwdata[`CTRL_FINE];
			event_only_select <= pwdata[`CTRL_EVENT_ONLY];
			master_node_select <= pwdata[`CTRL_MASTER_NODE];
			clock_node_type <= pwdata[`CTRL_NODE_HI:`CTRL_NODE_LO];
		end
		if (write_step)
			subsecond_step <= pwdata[`STEP_HI:0];
		if (write_offset_seconds)
			offset_seconds <= pwdata;
		if (write_offset_subseconds)
		begin
			offset_subseconds <= pwdata[`SUBSEC_HI:0];
			offset_negative <= pwdata[`SIGN_BIT];
		end
		if (write_addend)
			addend_value <= pwdata;
		if (write_target_seconds)
			target_seconds <= pwdata;
		if (write_target_nanoseconds)
			target_nanoseconds <= pwdata;
	end
end

// ==========================================================
// Registered views for the rest of the MAC
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		current_seconds <= 32'h00000000;
		current_subseconds <= 31'h0;
		current_time_sign <= 1'b0;
		snapshot_messages <= 6'h00;
	end
	else
	begin
		current_seconds <= system_time[62:31];
		current_subseconds <= system_time[30:0];
		current_time_sign <= system_time[63];
		snapshot_messages <= snapshot_set(clock_node_type, master_node_select,
			event_only_select);
	end
end

endmodule

// *** verilog/ptp_time_consts.vh ***
// Register offsets, field positions and reset values of the system time keeper
`ifndef PTP_TIME_CONSTS_VH
`define PTP_TIME_CONSTS_VH

// ==========================================================
// Register byte offsets
`define OFF_TIMESTAMP_CONTROL 12'h700
`define OFF_SUBSECOND_INCREMENT 12'h704
`define OFF_SYSTEM_TIME_SECONDS 12'h708
`define OFF_SYSTEM_TIME_SUBSECONDS 12'h70c
`define OFF_UPDATE_SECONDS 12'h710
`define OFF_UPDATE_SUBSECONDS 12'h714
`define OFF_FREQUENCY_ADDEND 12'h718
`define OFF_TARGET_TIME_SECONDS 12'h71c
`define OFF_TARGET_TIME_NANOSECONDS 12'h720

// ==========================================================
// Reset values
`define RST_TIMESTAMP_CONTROL 32'h00002000
`define RST_WORD 32'h00000000

// ==========================================================
// Control field positions
`define CTRL_ENABLE 0
`define CTRL_FINE 1
`define CTRL_INIT 2
`define CTRL_UPDATE 3
`define CTRL_ARM 4
`define CTRL_ADDEND_LOAD 5
`define CTRL_FIXED_ONE 13
`define CTRL_EVENT_ONLY 14
`define CTRL_MASTER_NODE 15
`define CTRL_NODE_LO 16
`define CTRL_NODE_HI 17

// ==========================================================
// Other field positions
`define STEP_HI 7
`define SUBSEC_HI 30
`define SIGN_BIT 31

// ==========================================================
// Clock-node type codes
`define NODE_BOUNDARY_E2E 2'h2
`define NODE_PEER 2'h3

// ==========================================================
// Snapshot mask bit positions
`define SNAP_SYNC 0
`define SNAP_FOLLOW_UP 1
`define SNAP_DELAY_REQ 2
`define SNAP_DELAY_RESP 3
`define SNAP_PDELAY_REQ 4
`define SNAP_PDELAY_RESP 5

`endif

// *** tb/ptp_time_clock_chk.sv ***
// Assertion checker for the precision time system clock
`timescale 1ns/10ps
module ptp_time_clock_chk
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire target_reached,
	input wire [31:0] current_seconds,
	input wire [30:0] current_subseconds,
	input wire current_time_sign,
	input wire [5:0] snapshot_messages
);
	// ==========================================
	// Control shadow: the checker sees only the bus writes
	reg en;
	reg fine;
	reg [7:0] step;
	wire wr = psel && penable && pwrite;
	wire [62:0] now = {current_seconds, current_subseconds};
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en <= 1'b0;
			fine <= 1'b0;
			step <= 8'h00;
		end
		else if (wr && paddr == 12'h700)
		begin
			en <= pwdata[0];
			fine <= pwdata[1];
		end
		else if (wr && paddr == 12'h704)
			step <= pwdata[7:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Three quiet cycles let any init or offset write drain out of the copy
	sequence coarse_run;
		(en && !fine && !wr)[*3];
	endsequence
	sequence held;
		(!en && !wr)[*3];
	endsequence
	ready_a: assert property (psel && penable |-> pready)
		else $error("pready low in access");
	unmapped_err_a: assert property (psel && penable && paddr[1:0] == 2'h0
		|-> pslverr == (paddr < 12'h700 || paddr > 12'h720))
		else $error("pslverr wrong");
	ctrl_fixed_a: assert property (psel && penable && !pwrite && paddr == 12'h700
		|-> prdata[13] && prdata[31:18] == 14'h0)
		else $error("control read bad");
	coarse_step_a: assert property (coarse_run |=> now == $past(now) + 63'(step))
		else $error("coarse step wrong");
	time_frozen_a: assert property (held |=> $stable(now))
		else $error("time moved while disabled");
	single_pulse_a: assert property (target_reached |=> (!target_reached)[*3])
		else $error("second target pulse");
	snap_peer_a: assert property (wr && paddr == 12'h700 && pwdata[17:16] == 2'h3
		&& pwdata[14] |-> ##2 snapshot_messages == 6'h31)
		else $error("peer snapshot mask");
	snap_ordinary_a: assert property (wr && paddr == 12'h700 && !pwdata[17]
		&& !pwdata[14] |-> ##2 snapshot_messages == 6'h0f)
		else $error("ordinary snapshot mask");
endmodule

bind ptp_time_clock ptp_time_clock_chk ptp_time_clock_chk_inst
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.target_reached(target_reached), .current_seconds(current_seconds),
	.current_subseconds(current_subseconds), .current_time_sign(current_time_sign),
	.snapshot_messages(snapshot_messages)
);

// *** tb/tb_ptp_time_clock.sv ***
// Self-checking testbench of the precision time system clock
`timescale 1ns/10ps
`include "ptp_time_consts.vh"
module tb_ptp_time_clock;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic target_reached, current_time_sign;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, t0, current_seconds;
	logic [30:0] current_subseconds;
	logic [5:0] snapshot_messages;
	logic [3:0] sel [8];
	logic [5:0] mask [8];
	int fails, n_checks, pulses;
	ptp_time_clock ptp_time_clock_inst
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.target_reached(target_reached), .current_seconds(current_seconds),
		.current_subseconds(current_subseconds), .current_time_sign(current_time_sign),
		.snapshot_messages(snapshot_messages)
	);
	// ==========================================
	// Bus and compare tasks
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50)
		begin
			@(posedge pclk);
			n++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			fails++;
	endtask
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] got);
		n_checks++;
		if (got !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, e, got);
		end
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("register %h", a), e, rd);
	endtask
	// Two reads three cycles apart measure the subsecond advance
	task automatic rate(input logic [31:0] e);
		apb(1'b0, `OFF_SYSTEM_TIME_SUBSECONDS, 32'h0);
		t0 = rd;
		apb(1'b0, `OFF_SYSTEM_TIME_SUBSECONDS, 32'h0);
		chk("subsecond advance", e, rd - t0);
	endtask
	task automatic results;
		$display("Comparisons %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ==========================================
	// Clock, watchdog and test sequence
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial
	begin
		#200000;
		fails++;
		results;
	end
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		fails = 0;
		n_checks = 0;
		sel = '{4'h0, 4'h3, 4'h1, 4'h7, 4'hc, 4'hd, 4'h8, 4'h9};
		mask = '{6'h0f, 6'h04, 6'h01, 6'h04, 6'h3f, 6'h31, 6'h0f, 6'h03};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 9; i++)
			rc(`OFF_TIMESTAMP_CONTROL + (12'(i) << 2), (i == 0) ? 32'h2000 : 32'h0);
		apb(1'b0, 12'h724, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, `OFF_SUBSECOND_INCREMENT, 32'h00000010);
		apb(1'b1, `OFF_UPDATE_SECONDS, 32'h00000005);
		apb(1'b1, `OFF_UPDATE_SUBSECONDS, 32'h00000100);
		apb(1'b1, `OFF_TIMESTAMP_CONTROL, 32'h00000004);
		rc(`OFF_TIMESTAMP_CONTROL, 32'h00002000);
		rc(`OFF_SYSTEM_TIME_SECONDS, 32'h00000005);
		rc(`OFF_SYSTEM_TIME_SUBSECONDS, 32'h00000100);
		apb(1'b1, `OFF_UPDATE_SECONDS, 32'h00000001);
		apb(1'b1, `OFF_UPDATE_SUBSECONDS, 32'h80000010);
		rc(`OFF_UPDATE_SUBSECONDS, 32'h80000010);
		apb(1'b1, `OFF_TIMESTAMP_CONTROL, 32'h00000008);
		rc(`OFF_TIMESTAMP_CONTROL, 32'h00002000);
		rc(`OFF_SYSTEM_TIME_SECONDS, 32'h00000004);
		rc(`OFF_SYSTEM_TIME_SUBSECONDS, 32'h000000f0);
		chk("current seconds", 32'h4, current_seconds);
		chk("current subseconds", 32'hf0, {1'b0, current_subseconds});
		chk("current sign", 32'h0, {31'h0, current_time_sign});
		apb(1'b1, `OFF_TIMESTAMP_CONTROL, 32'h00000001);
		rate(32'h00000030);
		apb(1'b1, `OFF_TIMESTAMP_CONTROL, 32'h00000003);
		rate(32'h00000000);
		apb(1'b1, `OFF_FREQUENCY_ADDEND, 32'hffffffff);
		rc(`OFF_FREQUENCY_ADDEND, 32'hffffffff);
		apb(1'b1, `OFF_TIMESTAMP_CONTROL, 32'h00000023);
		rc(`OFF_TIMESTAMP_CONTROL, 32'h00002003);
		rate(32'h00000030);
		// A target far ahead must leave the arm bit standing
		apb(1'b1, `OFF_TARGET_TIME_SECONDS, 32'h00000100);
		apb(1'b1, `OFF_TIMESTAMP_CONTROL, 32'h00000013);
		rc(`OFF_TIMESTAMP_CONTROL, 32'h00002013);
		apb(1'b1, `OFF_TARGET_TIME_SECONDS, 32'h00000004);
		pulses = 0;
		repeat (20) @(negedge pclk) pulses += (target_reached === 1'b1);
		chk("target pulses", 32'h1, 32'(pulses));
		rc(`OFF_TIMESTAMP_CONTROL, 32'h00002003);
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b1, `OFF_TIMESTAMP_CONTROL, {14'h0, sel[i], 14'h0});
			rc(`OFF_TIMESTAMP_CONTROL, {14'h0, sel[i], 14'h2000});
			chk("snapshot mask", {26'h0, mask[i]}, {26'h0, snapshot_messages});
		end
		results;
	end
endmodule
